// ---- hdl/bie_consts.vh ----
// bie_consts.vh: offsets, field positions, reset values and opcodes of the
// branch/increment execute block. assumes inclusion by bare name.
`ifndef BIE_CONSTS_VH
`define BIE_CONSTS_VH

// avalon byte offsets
`define BIE_OFS_INSTR      8'h00
`define BIE_OFS_ACC        8'h04
`define BIE_OFS_PC         8'h08
`define BIE_OFS_OPTION     8'h0c
`define BIE_OFS_HIZ_A      8'h10
`define BIE_OFS_HIZ_B      8'h14
`define BIE_OFS_HIZ_C      8'h18
`define BIE_OFS_STATE      8'h1c
`define BIE_OFS_PRESC      8'h20
`define BIE_OFS_FILE_BASE  8'h80

// file register indices
`define BIE_F_TIMER        5'h01
`define BIE_F_PCL          5'h02
`define BIE_F_STATUS       5'h03
`define BIE_F_PORT_A       5'h05
`define BIE_F_PORT_B       5'h06
`define BIE_F_PORT_C       5'h07

// field positions
`define BIE_STATUS_ZERO    2
`define BIE_STATUS_PAGE_HI 6
`define BIE_STATUS_PAGE_LO 5
`define BIE_OPTION_OWNER   3
`define BIE_DEST_BIT       5

// opcodes
`define BIE_OP_BRANCH      3'h5
`define BIE_OP_INCREMENT   6'h0a
`define BIE_OP_LOAD_DIR    9'h000

// reset values
`define BIE_RST_INSTR      12'h000
`define BIE_RST_ACC        8'h00
`define BIE_RST_PC         11'h7ff
`define BIE_RST_STATUS     8'h00
`define BIE_RST_OPTION     8'hff
`define BIE_RST_HIZ        8'hff
`define BIE_RST_FILE       8'h00
`define BIE_RST_PRESC      8'h00

// instruction cycle counts
`define BIE_CYC_SINGLE     2'h1
`define BIE_CYC_BRANCH     2'h2

`endif

// ---- hdl/bie_exec.v ----
// bie_exec.v: execute logic for the absolute branch, the increment-register
// and load-direction instructions, with port and prescaler side effects.
// assumes: core_clk is the instruction cycle clock, pins are synchronous,
// and software drives it as an avalon-mm master honouring waitrequest.
`timescale 1ns/1ps
`default_nettype none
`include "bie_consts.vh"

module bie_exec (
   // clock and reset
   input  wire        core_clk,
   input  wire        arst_n,
   // avalon-mm slave
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [3:0]  avs_byteenable,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   // first io port
   input  wire [7:0]  first_io_port_in,
   output wire [7:0]  first_io_port_out,
   output wire [7:0]  first_io_port_oe,
   // second io port
   input  wire [7:0]  second_io_port_in,
   output wire [7:0]  second_io_port_out,
   output wire [7:0]  second_io_port_oe,
   // third io port
   input  wire [7:0]  third_io_port_in,
   output wire [7:0]  third_io_port_out,
   output wire [7:0]  third_io_port_oe
);

   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_EXEC  = 2'h1;
   localparam [1:0] ST_FLUSH = 2'h2;

   reg [1:0]  state_q;
   reg [11:0] instr_q;
   reg [7:0]  acc_q;
   reg [10:0] pc_q;
   reg [7:0]  option_q;
   // tristate latches, one bit per pin, a one releases the pin
   reg [7:0]  hiz_a_q;
   reg [7:0]  hiz_b_q;
   reg [7:0]  hiz_c_q;
   reg [7:0]  presc_q;
   reg [1:0]  last_cycles_q;
   reg [1:0]  cyc_cnt_q;
   reg        rd_ready_q;
   reg [7:0]  file_q [0:31];

   integer i;

   // port index test, used by the load-direction decode
   function is_port;
      input [4:0] idx;
      begin
         is_port = (idx == `BIE_F_PORT_A) || (idx == `BIE_F_PORT_B) || (idx == `BIE_F_PORT_C);
      end
   endfunction

   // file register value as seen by the core: ports give pin levels
   function [7:0] file_view;
      input [4:0] idx;
      input [7:0] stored;
      input [7:0] pcl;
      input [7:0] pin_a;
      input [7:0] pin_b;
      input [7:0] pin_c;
      begin
         if (idx == `BIE_F_PORT_A) begin
            file_view = pin_a;
         end else if (idx == `BIE_F_PORT_B) begin
            file_view = pin_b;
         end else if (idx == `BIE_F_PORT_C) begin
            file_view = pin_c;
         end else if (idx == `BIE_F_PCL) begin
            file_view = pcl;
         end else begin
            file_view = stored;
         end
      end
   endfunction

   // register window codes, shared by the bus read and write paths
   localparam [3:0] SEL_NONE   = 4'h0;
   localparam [3:0] SEL_FILE   = 4'h1;
   localparam [3:0] SEL_INSTR  = 4'h2;
   localparam [3:0] SEL_ACC    = 4'h3;
   localparam [3:0] SEL_PC     = 4'h4;
   localparam [3:0] SEL_OPTION = 4'h5;
   localparam [3:0] SEL_HIZ_A  = 4'h6;
   localparam [3:0] SEL_HIZ_B  = 4'h7;
   localparam [3:0] SEL_HIZ_C  = 4'h8;
   localparam [3:0] SEL_STATE  = 4'h9;
   localparam [3:0] SEL_PRESC  = 4'ha;

   // address decode; the file window ignores the two low address bits
   function [3:0] reg_sel;
      input [7:0] addr;
      begin
         if (addr[7] == 1'b1) begin
            reg_sel = SEL_FILE;
         end else if (addr == `BIE_OFS_INSTR) begin
            reg_sel = SEL_INSTR;
         end else if (addr == `BIE_OFS_ACC) begin
            reg_sel = SEL_ACC;
         end else if (addr == `BIE_OFS_PC) begin
            reg_sel = SEL_PC;
         end else if (addr == `BIE_OFS_OPTION) begin
            reg_sel = SEL_OPTION;
         end else if (addr == `BIE_OFS_HIZ_A) begin
            reg_sel = SEL_HIZ_A;
         end else if (addr == `BIE_OFS_HIZ_B) begin
            reg_sel = SEL_HIZ_B;
         end else if (addr == `BIE_OFS_HIZ_C) begin
            reg_sel = SEL_HIZ_C;
         end else if (addr == `BIE_OFS_STATE) begin
            reg_sel = SEL_STATE;
         end else if (addr == `BIE_OFS_PRESC) begin
            reg_sel = SEL_PRESC;
         end else begin
            reg_sel = SEL_NONE;
         end
      end
   endfunction

   // instruction decode
   wire       busy       = (state_q != ST_IDLE);
   wire       dec_branch = (instr_q[11:9] == `BIE_OP_BRANCH);
   wire       dec_inc    = (instr_q[11:6] == `BIE_OP_INCREMENT);
   wire       dec_ldir   = (instr_q[11:3] == `BIE_OP_LOAD_DIR) && is_port(instr_q[4:0]);
   wire       dest_reg   = instr_q[`BIE_DEST_BIT];
   wire [4:0] fidx       = instr_q[4:0];

   // operand fetch and increment
   wire [7:0] operand = file_view(fidx, file_q[fidx], pc_q[7:0], first_io_port_in,
                                  second_io_port_in, third_io_port_in);
   wire [7:0] inc_res = operand + 8'h01;
   wire       res_zero = (inc_res == 8'h00);
   wire [7:0] status_now = file_q[`BIE_F_STATUS];
   wire       presc_timer = ~option_q[`BIE_OPTION_OWNER];
   // sequential fetch address for every word except a branch and an increment into the low counter byte
   wire [10:0] pc_next = pc_q + 11'h001;

   // bus decode
   // writes wait while an instruction runs; reads always wait one cycle
   wire       wr_take  = avs_write & ~busy;
   wire       rd_take  = avs_read & ~rd_ready_q;
   wire [3:0] bus_sel  = reg_sel(avs_address);
   wire       file_hit = (bus_sel == SEL_FILE);
   wire [4:0] bus_fidx = avs_address[6:2];

   assign avs_waitrequest = (avs_read & ~rd_ready_q) | (avs_write & busy);

   // pins: latch drives data, tristate one releases the pin
   assign first_io_port_out  = file_q[`BIE_F_PORT_A];
   assign second_io_port_out = file_q[`BIE_F_PORT_B];
   assign third_io_port_out  = file_q[`BIE_F_PORT_C];
   assign first_io_port_oe   = ~hiz_a_q;
   assign second_io_port_oe  = ~hiz_b_q;
   assign third_io_port_oe   = ~hiz_c_q;

   // read data captured one cycle after the request appears
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_ready_q   <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         rd_ready_q <= rd_take;
         if (rd_take) begin
            if (file_hit) begin
               avs_readdata <= {24'h000000, file_view(bus_fidx, file_q[bus_fidx], pc_q[7:0],
                               first_io_port_in, second_io_port_in, third_io_port_in)};
            end else if (bus_sel == SEL_INSTR) begin
               avs_readdata <= {20'h00000, instr_q};
            end else if (bus_sel == SEL_ACC) begin
               avs_readdata <= {24'h000000, acc_q};
            end else if (bus_sel == SEL_PC) begin
               avs_readdata <= {21'h000000, pc_q};
            end else if (bus_sel == SEL_OPTION) begin
               avs_readdata <= {24'h000000, option_q};
            end else if (bus_sel == SEL_HIZ_A) begin
               avs_readdata <= {24'h000000, hiz_a_q};
            end else if (bus_sel == SEL_HIZ_B) begin
               avs_readdata <= {24'h000000, hiz_b_q};
            end else if (bus_sel == SEL_HIZ_C) begin
               avs_readdata <= {24'h000000, hiz_c_q};
            end else if (bus_sel == SEL_STATE) begin
               avs_readdata <= {28'h0000000, last_cycles_q, 1'b0, busy};
            end else if (bus_sel == SEL_PRESC) begin
               avs_readdata <= {24'h000000, presc_q};
            end else begin
               avs_readdata <= 32'h0000_0000;
            end
         end
      end
   end

   // execution engine and register writes
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q       <= ST_IDLE;
         instr_q       <= `BIE_RST_INSTR;
         acc_q         <= `BIE_RST_ACC;
         pc_q          <= `BIE_RST_PC;
         option_q      <= `BIE_RST_OPTION;
         hiz_a_q       <= `BIE_RST_HIZ;
         hiz_b_q       <= `BIE_RST_HIZ;
         hiz_c_q       <= `BIE_RST_HIZ;
         presc_q       <= `BIE_RST_PRESC;
         last_cycles_q <= 2'h0;
         cyc_cnt_q     <= 2'h0;
         for (i = 0; i < 32; i = i + 1) begin
            file_q[i] <= `BIE_RST_FILE;
         end
      end else begin
         // prescaler runs only while owned by the timer
         if (presc_timer) begin
            presc_q <= presc_q + 8'h01;
         end
         case (state_q)
            ST_IDLE: begin
               if (wr_take) begin
                  if (file_hit) begin
                     // the low counter byte is written only through the counter register
                     if (avs_byteenable[0] && (bus_fidx != `BIE_F_PCL)) begin
                        file_q[bus_fidx] <= avs_writedata[7:0];
                     end
                  end else if (bus_sel == SEL_INSTR) begin
                     if (avs_byteenable[0]) begin
                        instr_q[7:0] <= avs_writedata[7:0];
                     end
                     if (avs_byteenable[1]) begin
                        instr_q[11:8] <= avs_writedata[11:8];
                     end
                     state_q   <= ST_EXEC;
                     cyc_cnt_q <= 2'h1;
                  end else if (bus_sel == SEL_ACC) begin
                     if (avs_byteenable[0]) begin
                        acc_q <= avs_writedata[7:0];
                     end
                  end else if (bus_sel == SEL_PC) begin
                     if (avs_byteenable[0]) begin
                        pc_q[7:0] <= avs_writedata[7:0];
                     end
                     if (avs_byteenable[1]) begin
                        pc_q[10:8] <= avs_writedata[10:8];
                     end
                  end else if (bus_sel == SEL_OPTION) begin
                     if (avs_byteenable[0]) begin
                        option_q <= avs_writedata[7:0];
                     end
                  end else if (bus_sel == SEL_HIZ_A) begin
                     if (avs_byteenable[0]) begin
                        hiz_a_q <= avs_writedata[7:0];
                     end
                  end else if (bus_sel == SEL_HIZ_B) begin
                     if (avs_byteenable[0]) begin
                        hiz_b_q <= avs_writedata[7:0];
                     end
                  end else if (bus_sel == SEL_HIZ_C) begin
                     if (avs_byteenable[0]) begin
                        hiz_c_q <= avs_writedata[7:0];
                     end
                  end
               end
            end
            ST_EXEC: begin
               if (dec_branch) begin
                  pc_q      <= {status_now[`BIE_STATUS_PAGE_HI:`BIE_STATUS_PAGE_LO],
                                instr_q[8:0]};
                  state_q   <= ST_FLUSH;
                  cyc_cnt_q <= `BIE_CYC_BRANCH;
               end else if (dec_inc) begin
                  if (dest_reg) begin
                     if (fidx == `BIE_F_PCL) begin
                        // page bits kept, bit 8 cleared, low byte from the result
                        pc_q <= {pc_q[10:9], 1'b0, inc_res};
                     end else begin
                        pc_q      <= pc_next;
                        file_q[fidx] <= inc_res;
                     end
                  end else begin
                     acc_q <= inc_res;
                     pc_q  <= pc_next;
                  end
                  // zero flag overrides the status byte even when it is the target
                  if (dest_reg && (fidx == `BIE_F_STATUS)) begin
                     file_q[`BIE_F_STATUS] <= {inc_res[7:3], res_zero, inc_res[1:0]};
                  end else begin
                     file_q[`BIE_F_STATUS] <= {status_now[7:3], res_zero, status_now[1:0]};
                  end
                  // clear wins over the free-running count above
                  if (dest_reg && (fidx == `BIE_F_TIMER) && presc_timer) begin
                     presc_q <= `BIE_RST_PRESC;
                  end
                  state_q       <= ST_IDLE;
                  last_cycles_q <= `BIE_CYC_SINGLE;
               end else begin
                  if (dec_ldir) begin
                     // only port indices decode here; other words run as a no-op
                     if (fidx == `BIE_F_PORT_A) begin
                        hiz_a_q <= acc_q;
                     end else if (fidx == `BIE_F_PORT_B) begin
                        hiz_b_q <= acc_q;
                     end else begin
                        hiz_c_q <= acc_q;
                     end
                  end
                  pc_q          <= pc_next;
                  state_q       <= ST_IDLE;
                  last_cycles_q <= `BIE_CYC_SINGLE;
               end
            end
            ST_FLUSH: begin
               // second branch cycle: fetched word discarded, only the cycle count is recorded
               state_q       <= ST_IDLE;
               last_cycles_q <= cyc_cnt_q;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ---- tb/bie_exec_chk.sv ----
// bie_exec_chk.sv: bus timing and port update checks for bie_exec.
// assumes a bind from the bench onto the block.
`timescale 1ns/1ps
`default_nettype none
`include "bie_consts.vh"
module bie_exec_chk (
   input wire logic        core_clk,
   input wire logic        arst_n,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [7:0]  first_io_port_oe,
   input wire logic [7:0]  second_io_port_out
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   wire logic wr_ok = avs_write && !avs_waitrequest;
   wire logic ins = wr_ok && avs_address == `BIE_OFS_INSTR && avs_byteenable[1:0] == 2'h3;
   a_branch_busy: assert property (ins && avs_writedata[11:9] == 3'h5 |=>
      (!avs_write || avs_waitrequest)[*2] ##1 (!avs_write || !avs_waitrequest)) else $error("branch busy time");
   a_incr_busy: assert property (ins && avs_writedata[11:6] == 6'h0a |=>
      (!avs_write || avs_waitrequest) ##1 (!avs_write || !avs_waitrequest)) else $error("increment busy time");
   a_oe_cause: assert property ($changed(first_io_port_oe) |-> $past(wr_ok) || $past(wr_ok, 2))
      else $error("enable changed without write");
   a_out_cause: assert property ($changed(second_io_port_out) |-> $past(wr_ok) || $past(wr_ok, 2))
      else $error("latch changed without write");
   a_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("read wait not one cycle");
   a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata)) else $error("read data moved");
   a_write_bound: assert property (avs_write && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
      else $error("write waited too long");
   a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 8'h24 |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ---- tb/bie_pins.sv ----
// bie_pins.sv: far side of one io port, pins follow the block where it
// drives and an external device elsewhere. assumes 8-bit ports.
`timescale 1ns/1ps
`default_nettype none
module bie_pins (
   // from the block
   input  wire logic [7:0] drv_out,
   input  wire logic [7:0] drv_oe,
   // external device
   input  wire logic [7:0] ext_lvl,
   // to the block
   output wire logic [7:0] pin_lvl
);
   assign pin_lvl = (drv_out & drv_oe) | (ext_lvl & ~drv_oe);
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// tb_top.sv: self-checking bench for bie_exec over avalon-mm.
// assumes bie_pins stands on each io port.
`timescale 1ns/1ps
`default_nettype none
`include "bie_consts.vh"
module tb_top;
   logic            core_clk = 1'b0;
   logic            arst_n = 1'b0;
   logic [7:0]      avs_address = 8'h00;
   logic            avs_read = 1'b0;
   logic            avs_write = 1'b0;
   logic [3:0]      avs_byteenable = 4'h0;
   logic [31:0]     avs_writedata = 32'h0;
   wire logic [31:0] avs_readdata;
   wire logic       avs_waitrequest;
   logic [7:0]      ext_q [3];
   wire logic [7:0] p_in [3];
   wire logic [7:0] p_out [3];
   wire logic [7:0] p_oe [3];
   integer          mismatches = 0;
   integer          total_checks = 0;
   logic [31:0]     rd;
   logic [31:0]     p1;
   integer          i;
   always #25 core_clk = ~core_clk;
   bie_exec dut (.core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .first_io_port_in(p_in[0]), .first_io_port_out(p_out[0]), .first_io_port_oe(p_oe[0]),
      .second_io_port_in(p_in[1]), .second_io_port_out(p_out[1]), .second_io_port_oe(p_oe[1]),
      .third_io_port_in(p_in[2]), .third_io_port_out(p_out[2]), .third_io_port_oe(p_oe[2]));
   for (genvar g = 0; g < 3; g++) begin : pins
      bie_pins pm (.drv_out(p_out[g]), .drv_oe(p_oe[g]), .ext_lvl(ext_q[g]), .pin_lvl(p_in[g]));
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      total_checks++;
      if (got !== ex) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      integer n;
      @(posedge core_clk);
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= 4'h3;
      for (n = 0; n < 20; n++) begin
         @(posedge core_clk);
         if (avs_waitrequest === 1'b0)
            break;
      end
      if (n == 20) begin
         mismatches++;
         final_report();
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] ex, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, ex, rd);
   endtask
   function automatic logic [7:0] fa(input int f);
      return 8'(`BIE_OFS_FILE_BASE + 4 * f);
   endfunction
   initial begin
      ext_q = '{8'h0f, 8'h5a, 8'hc3};
      repeat (20) @(posedge core_clk);
      arst_n <= 1'b1;
      rdchk(`BIE_OFS_PC, 32'h7ff, "pc");
      rdchk(`BIE_OFS_HIZ_A, 32'hff, "hiz");
      chk("oe", 32'h0, {8'h0, p_oe[0], p_oe[1], p_oe[2]});
      rdchk(8'h24, 32'h0, "unmapped");
      $display("test reset done");
      bus(1'b1, fa(3), 32'h60);
      bus(1'b1, `BIE_OFS_INSTR, 32'hb23);
      bus(1'b1, `BIE_OFS_ACC, 32'h33);
      rdchk(`BIE_OFS_PC, 32'h723, "pc");
      rdchk(fa(3), 32'h60, "status");
      rdchk(`BIE_OFS_STATE, 32'h8, "state");
      rdchk(`BIE_OFS_ACC, 32'h33, "acc late");
      $display("test branch done");
      bus(1'b1, `BIE_OFS_ACC, 32'h33);
      bus(1'b1, fa(16), 32'hff);
      bus(1'b1, `BIE_OFS_INSTR, 32'h290);
      rdchk(`BIE_OFS_ACC, 32'h00, "acc");
      rdchk(fa(16), 32'hff, "file");
      rdchk(fa(3), 32'h64, "zero set");
      rdchk(`BIE_OFS_STATE, 32'h4, "state");
      bus(1'b1, `BIE_OFS_INSTR, 32'h2b0);
      bus(1'b1, `BIE_OFS_INSTR, 32'h2b0);
      rdchk(fa(16), 32'h01, "file");
      rdchk(fa(3), 32'h60, "zero clr");
      rdchk(`BIE_OFS_ACC, 32'h00, "acc");
      bus(1'b1, `BIE_OFS_PC, 32'h5fe);
      bus(1'b1, `BIE_OFS_INSTR, 32'h2a2);
      rdchk(`BIE_OFS_PC, 32'h4ff, "pc");
      bus(1'b1, `BIE_OFS_INSTR, 32'h2a3);
      rdchk(fa(3), 32'h61, "status inc");
      $display("test increment done");
      for (i = 0; i < 3; i++) begin
         bus(1'b1, fa(5 + i), 32'hff);
         bus(1'b1, `BIE_OFS_INSTR, 32'h2a5 + i);
         repeat (2) @(negedge core_clk);
         chk("latch", {24'h0, ext_q[i] + 8'h1}, {24'h0, p_out[i]});
         bus(1'b1, `BIE_OFS_ACC, {24'h0, ~ext_q[i]});
         bus(1'b1, `BIE_OFS_INSTR, 32'h5 + i);
         rdchk(8'(`BIE_OFS_HIZ_A + 4 * i), {24'h0, ~ext_q[i]}, "hiz");
         chk("oe", {24'h0, ext_q[i]}, {24'h0, p_oe[i]});
         rdchk(fa(5 + i), {24'h0, (ext_q[i] + 8'h1) & ext_q[i]}, "pins");
      end
      $display("test ports done");
      bus(1'b1, `BIE_OFS_OPTION, 32'hf7);
      repeat (40) @(posedge core_clk);
      bus(1'b0, `BIE_OFS_PRESC, 32'h0);
      chk("presc run", 32'h1, {31'h0, rd > 32'd30});
      bus(1'b1, `BIE_OFS_INSTR, 32'h2a1);
      bus(1'b0, `BIE_OFS_PRESC, 32'h0);
      chk("presc clr", 32'h1, {31'h0, rd < 32'd8});
      bus(1'b1, `BIE_OFS_OPTION, 32'hff);
      bus(1'b0, `BIE_OFS_PRESC, 32'h0);
      p1 = rd;
      bus(1'b1, `BIE_OFS_INSTR, 32'h2a1);
      rdchk(`BIE_OFS_PRESC, p1, "presc kept");
      $display("test prescaler done");
      final_report();
   end
endmodule
bind bie_exec bie_exec_chk chk_i (.core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .first_io_port_oe(first_io_port_oe), .second_io_port_out(second_io_port_out));
`default_nettype wire
